// ==== verif/mmac_cpu_model.sv ====
// Purpose: Processor core model issuing accesses and events
// Assumes: Requests last one cycle after a rising edge
// Notes: Released fields show inverted values, not stale ones, except event flags, which clear to zero
`timescale 1ns/1ps
module mmac_cpu_model
  import mmac_pkg::*;
(
  input wire logic ref_clk,
  output mmac_macc_t cpu_mem,
  output mmac_sacc_t cpu_sfr,
  output mmac_evt_t cpu_evt
);
  // ==========
  // Requests
  initial begin
    cpu_mem = '0;
    cpu_sfr = '0;
    cpu_evt = '0;
  end
  task automatic mem(input logic w, input logic f, input logic [AW-1:0] a);
    @(posedge ref_clk);
    cpu_mem <= '{1'b1, w, f, a};
    @(posedge ref_clk);
    cpu_mem <= '{1'b0, ~w, ~f, ~a};
  endtask
  task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    cpu_sfr <= '{1'b1, w, a, d};
    @(posedge ref_clk);
    cpu_sfr <= '{1'b0, ~w, ~a, ~d};
  endtask
  task automatic evt(input mmac_evt_t e);
    @(posedge ref_clk);
    cpu_evt <= e;
    @(posedge ref_clk);
    cpu_evt <= {8'h0, ~e.call_addr};
  endtask
endmodule

// ==== verif/mmac_monitor.sv ====
// Purpose: Port checks of the access control unit
// Assumes: One clock, one-cycle requests
// Notes: Bound to every mmac_unit
`timescale 1ns/1ps
module mmac_monitor
  import mmac_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [RAW-1:0] reg_addr,
  input wire logic reg_wr,
  input wire mmac_macc_t cpu_mem,
  input wire mmac_sacc_t cpu_sfr,
  input wire mmac_evt_t cpu_evt,
  input wire mmac_macc_t mem_out,
  input wire mmac_sacc_t sfr_out,
  input wire logic [4:0] mode_out,
  input wire logic exc_pulse,
  input wire logic dev_reset_req,
  input wire logic push_suppress
);
  // ==========
  // Helpers
  logic seen_reg;
  logic fault;
  assign fault = exc_pulse | dev_reset_req;
  // Sticky: a reset request needs an earlier exception
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_reg <= 1'b0;
    end else if (exc_pulse) begin
      seen_reg <= 1'b1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ==========
  // Assertions
  // forward timing
  AST_FWD: assert property (
    mem_out.valid |-> $past(cpu_mem.valid) && mem_out.wr == $past(cpu_mem.wr))
    else $error("forward without request");
  AST_IDENT: assert property (
    mem_out.valid && $past(mode_out) != 5'h10 |-> mem_out.addr == $past(cpu_mem.addr))
    else $error("address moved outside user");
  AST_FW: assert property (
    mem_out.valid && $past(mode_out) inside {5'h01, 5'h04} |-> mem_out.addr inside
    {[EE_FW_LO:EE_FW_HI], [RAM_FW_LO:RAM_FW_HI], [ROM_TEST_LO:ROM_TEST_HI]})
    else $error("firmware mode left its part");
  AST_APP: assert property (
    mem_out.valid && $past(mode_out) inside {5'h08, 5'h10} |-> mem_out.addr inside
    {[EE_APP_LO:EE_APP_HI], [RAM_APP_LO:RAM_APP_HI], [ROM_APP_LO:ROM_APP_HI]})
    else $error("application mode left its part");
  AST_ANS: assert property ($past(cpu_mem.valid) |-> mem_out.valid || fault)
    else $error("access neither passed nor faulted");
  AST_SUPP: assert property (fault && !$past(cpu_sfr.valid) |-> !mem_out.valid)
    else $error("faulting access reached memory");
  AST_SFR: assert property (fault && !$past(cpu_mem.valid) |-> !sfr_out.valid)
    else $error("faulting register access passed");
  AST_2ND: assert property (dev_reset_req |-> seen_reg)
    else $error("reset request without exception");
  AST_ENTRY: assert property (
    push_suppress |-> mode_out == 5'h10 && $past(mode_out) == 5'h08 && $past(cpu_evt.call_addr) == ENTRY_ADDR)
    else $error("bad entry call");
  AST_CLR: assert property (
    reg_wr && reg_addr == OFF_MODE && cpu_evt[31:AW] == '0 && mode_out == 5'h10 |=> mode_out == 5'h10)
    else $error("mode write raised privilege");
  AST_SYSTEM_VECTOR_CALL: assert property (
    cpu_evt.system_vector_call && mode_out != 5'h10 |=> fault && $stable(mode_out))
    else $error("system vector not refused");
  AST_KEY: assert property (
    cpu_sfr.valid && !cpu_sfr.wr && cpu_sfr.addr inside {[SFR_KEY_LO:SFR_KEY_HI]} |=> fault && !sfr_out.valid)
    else $error("key register read");
  cover property (push_suppress);
  cover property (dev_reset_req);
  cover property (mem_out.valid && $past(mode_out) == 5'h10);
endmodule
bind mmac_unit mmac_monitor u_mon (.ref_clk, .rst_n, .reg_addr, .reg_wr, .cpu_mem, .cpu_sfr, .cpu_evt,
  .mem_out, .sfr_out, .mode_out, .exc_pulse, .dev_reset_req, .push_suppress);

// ==== verif/mmac_unit_tb_top.sv ====
// Purpose: Self-checking bench of the access control unit
// Assumes: Core model drives accesses, bench the register port
// Notes: Later faults may show as reset requests
`timescale 1ns/1ps
module mmac_unit_tb_top
  import mmac_pkg::*;
;
  typedef struct packed {
    logic s;
    logic w;
    logic f;
    logic [AW-1:0] a;
    logic ok;
    logic [AW-1:0] pa;
  } mmac_row_t;
  logic ref_clk;
  logic rst_n;
  logic [RAW-1:0] reg_addr;
  logic [DW-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [DW-1:0] reg_rdata;
  mmac_macc_t cpu_mem;
  mmac_sacc_t cpu_sfr;
  mmac_evt_t cpu_evt;
  mmac_macc_t mem_out;
  mmac_sacc_t sfr_out;
  logic [7:0] sfr_rdata;
  logic [4:0] mode_out;
  logic exc_pulse;
  logic dev_reset_req;
  logic push_suppress;
  logic fault;
  int fails = 0;
  int n_compared = 0;
  assign fault = exc_pulse | dev_reset_req;
  // User cases: segment 0 rwx, 1 read only, 2 relocated out
  localparam mmac_row_t ROWS [12] = '{
    '{1'b0, 1'b0, 1'b0, 24'h000010, 1'b1, 24'h090010},
    '{1'b0, 1'b1, 1'b0, 24'h000020, 1'b1, 24'h090020},
    '{1'b0, 1'b0, 1'b1, 24'h000030, 1'b1, 24'h090030},
    '{1'b0, 1'b0, 1'b1, 24'h001010, 1'b0, 24'h0},
    '{1'b0, 1'b1, 1'b0, 24'h001020, 1'b0, 24'h0},
    '{1'b0, 1'b0, 1'b0, 24'h001010, 1'b1, 24'h001010},
    '{1'b0, 1'b0, 1'b0, 24'h003000, 1'b0, 24'h0},
    '{1'b0, 1'b0, 1'b0, 24'h002000, 1'b0, 24'h0},
    '{1'b1, 1'b0, 1'b0, 24'h000000, 1'b1, 24'h0},
    '{1'b1, 1'b0, 1'b0, 24'h000008, 1'b0, 24'h0},
    '{1'b1, 1'b1, 1'b0, 24'h000080, 1'b0, 24'h0},
    '{1'b1, 1'b0, 1'b0, 24'h0000a0, 1'b0, 24'h0}
  };
  mmac_cpu_model cpu (.ref_clk, .cpu_mem, .cpu_sfr, .cpu_evt);
  mmac_unit dut (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_mem,
    .cpu_sfr, .cpu_evt, .mem_out, .sfr_out, .sfr_rdata, .mode_out, .exc_pulse, .dev_reset_req, .push_suppress);
  // ==========
  // Clock and tasks
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("BAD t=%0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wreg(input logic [RAW-1:0] a, input logic [DW-1:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rreg(input logic [RAW-1:0] a, input logic [DW-1:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  task automatic seg(input logic [31:0] i, r, s, e, o);
    wreg(OFF_SEG_INDEX, i);
    wreg(OFF_SEG_RIGHTS, r);
    wreg(OFF_SEG_START, s);
    wreg(OFF_SEG_END, e);
    wreg(OFF_SEG_OFFSET, o);
  endtask
  // One access; whole forwarded carrier compared
  task automatic row(input mmac_row_t r);
    if (r.s) cpu.sfr(r.w, r.a[7:0], 8'h3c);
    else cpu.mem(r.w, r.f, r.a);
    #1;
    if (r.s) chk(32'(sfr_out), 32'({r.ok, r.w & r.ok, r.pa[7:0], r.ok ? 8'h3c : 8'h00}));
    else chk(32'(mem_out), 32'({r.ok, r.w & r.ok, r.f & r.ok, r.pa}));
    chk(32'(fault), 32'(!r.ok));
  endtask
  // Bit 31 sys vector, 30 fw vector, 29 return, 28 irq, 27..25 calls
  function automatic mmac_evt_t ev_of(input int b);
    mmac_evt_t e;
    e = '0;
    e[b] = 1'b1;
    e.call_addr = ENTRY_ADDR;
    return e;
  endfunction
  task automatic go(input int b, input logic [4:0] m);
    cpu.evt(ev_of(b));
    #1;
    chk(32'(mode_out), 32'(m));
  endtask
  task automatic bank(input logic w, input logic [7:0] d);
    if (w) cpu.sfr(1'b1, SFR_BANKED, d);
    cpu.sfr(1'b0, SFR_BANKED, 8'h0);
    #1;
    chk(32'(sfr_rdata), 32'(d));
  endtask
  // ==========
  // Main sequence
  initial begin
    rst_n = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    chk(32'(mode_out), 32'h1);
    row('{1'b0, 1'b0, 1'b0, 24'h080010, 1'b1, 24'h080010});
    row('{1'b0, 1'b0, 1'b0, 24'h090000, 1'b0, 24'h0});
    row('{1'b0, 1'b0, 1'b0, 24'h300000, 1'b0, 24'h0});
    chk(32'(dev_reset_req), 32'h1);
    // Mid-run reset clears all state
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    go(24, 5'h02);
    row('{1'b0, 1'b0, 1'b0, 24'h090000, 1'b1, 24'h090000});
    row('{1'b0, 1'b0, 1'b0, 24'h300000, 1'b1, 24'h300000});
    go(28, 5'h08);
    seg(32'h0, 32'h00010004, 32'h0, 32'h000fff, 32'h090000);
    seg(32'h1, 32'h1, 32'h001000, 32'h001fff, 32'h0);
    seg(32'h2, 32'h3, 32'h002000, 32'h002fff, 32'h07e000);
    wreg(OFF_SEG_INDEX, 32'h3);
    wreg(OFF_SEG_RIGHTS, 32'h7);
    wreg(OFF_SEG_INDEX, 32'h1);
    rreg(OFF_SEG_END, 32'h001fff);
    rreg(8'h40, 32'h0);
    rreg(OFF_MODE, 32'h8);
    row('{1'b0, 1'b0, 1'b0, 24'h000010, 1'b1, 24'h000010});
    row('{1'b1, 1'b1, 1'b0, 24'h000081, 1'b1, 24'h000081});
    row('{1'b1, 1'b0, 1'b0, 24'h000081, 1'b0, 24'h0});
    row('{1'b1, 1'b0, 1'b0, 24'h000088, 1'b1, 24'h000088});
    bank(1'b1, 8'h5a);
    for (int k = 27; k >= 25; k--) begin
      go(k, 5'h10);
      chk(32'(push_suppress), 32'h1);
      if (k > 25) go(31, 5'h08);
    end
    foreach (ROWS[i]) row(ROWS[i]);
    bank(1'b1, 8'ha5);
    wreg(OFF_MODE, 32'h1f);
    #1;
    chk(32'(mode_out), 32'h10);
    go(31, 5'h08);
    bank(1'b0, 8'h5a);
    go(29, 5'h10);
    go(29, 5'h10);
    chk(32'(exc_pulse), 32'h1);
    go(30, 5'h04);
    go(31, 5'h04);
    chk(32'(fault), 32'h1);
    repeat (2) @(posedge ref_clk);
    complete_run();
  end
  // Watchdog well past the expected run length
  initial begin
    #200000;
    fails++;
    complete_run();
  end
endmodule

// ==== verilog/mmac_pkg.sv ====
// Purpose: Shared constants and carriers of the mode and memory access control unit
// Assumes: 24-bit CPU address space, 8-bit special function register space
// Notes: Partition bounds are fixed at build time and have no write path
package mmac_pkg;

  // ==========================================================================
  // Widths and sizes
  localparam int AW = 24;
  localparam int SEG_NUM = 64;
  localparam int SEG_IW = 6;
  localparam int SFR_GROUPS = 16;
  localparam int RAW = 8;
  localparam int DW = 32;

  // ==========================================================================
  // Segment rights codes
  localparam logic [2:0] RIGHT_NONE = 3'h0;
  localparam logic [2:0] RIGHT_R = 3'h1;
  localparam logic [2:0] RIGHT_RX = 3'h2;
  localparam logic [2:0] RIGHT_RW = 3'h3;
  localparam logic [2:0] RIGHT_RWX = 3'h4;
  localparam logic [2:0] RIGHT_SKIP = 3'h6; // Entry unused, search goes on
  localparam logic [2:0] RIGHT_END = 3'h7; // Table ends here, search stops

  // ==========================================================================
  // CPU modes, one-hot
  typedef enum logic [4:0] {
    MODE_BOOT = 5'h01,
    MODE_TEST = 5'h02,
    MODE_FW = 5'h04,
    MODE_SYS = 5'h08,
    MODE_USER = 5'h10
  } mmac_mode_t;

  // Interrupt execution mode choices
  localparam logic [1:0] IRQ_IN_USER = 2'h0;
  localparam logic [1:0] IRQ_IN_SYS = 2'h1;
  localparam logic [1:0] IRQ_IN_FW = 2'h2;

  // ==========================================================================
  // Fixed physical partitions
  localparam logic [AW-1:0] ROM_APP_LO = 24'h000000;
  localparam logic [AW-1:0] ROM_APP_HI = 24'h03ffff;
  localparam logic [AW-1:0] ROM_TEST_LO = 24'h040000;
  localparam logic [AW-1:0] ROM_TEST_HI = 24'h04ffff;
  localparam logic [AW-1:0] EE_FW_LO = 24'h080000;
  localparam logic [AW-1:0] EE_FW_HI = 24'h08ffff;
  localparam logic [AW-1:0] EE_APP_LO = 24'h090000;
  localparam logic [AW-1:0] EE_APP_HI = 24'h0fffff;
  localparam logic [AW-1:0] RAM_FW_LO = 24'h100000;
  localparam logic [AW-1:0] RAM_FW_HI = 24'h1007ff;
  localparam logic [AW-1:0] RAM_APP_LO = 24'h100800;
  localparam logic [AW-1:0] RAM_APP_HI = 24'h101fff;
  localparam logic [AW-1:0] ENTRY_ADDR = 24'h800000;

  // ==========================================================================
  // Configuration register offsets
  localparam logic [RAW-1:0] OFF_MODE = 8'h00;
  localparam logic [RAW-1:0] OFF_IRQ_MODE = 8'h04;
  localparam logic [RAW-1:0] OFF_SEG_INDEX = 8'h08;
  localparam logic [RAW-1:0] OFF_SEG_RIGHTS = 8'h0c;
  localparam logic [RAW-1:0] OFF_SEG_START = 8'h10;
  localparam logic [RAW-1:0] OFF_SEG_END = 8'h14;
  localparam logic [RAW-1:0] OFF_SEG_OFFSET = 8'h18;
  localparam logic [RAW-1:0] OFF_FW_SFR = 8'h1c;
  localparam logic [RAW-1:0] OFF_STATUS = 8'h20;
  localparam int SEG_SFR_POS = 16; // Segment SFR rights in rights word

  // ==========================================================================
  // Special function register map
  localparam logic [7:0] SFR_GROUP_LIMIT = 8'h80;
  localparam logic [7:0] SFR_KEY_LO = 8'h80;
  localparam logic [7:0] SFR_KEY_HI = 8'h87;
  localparam logic [7:0] SFR_RNG = 8'h88;
  localparam logic [7:0] SFR_BANKED = 8'h90;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [2:0] rights;
    logic [AW-1:0] start_a;
    logic [AW-1:0] end_a;
    logic [AW-1:0] offset;
    logic [SFR_GROUPS-1:0] sfr;
  } mmac_seg_t;

  typedef struct packed {
    logic system_vector_call;
    logic firmware_vector_call;
    logic return_from_interrupt;
    logic irq_entry;
    logic long_call_instr;
    logic absolute_call_instr;
    logic extended_call_instr;
    logic test_entry;
    logic [AW-1:0] call_addr;
  } mmac_evt_t;

  typedef struct packed {
    logic valid;
    logic wr;
    logic fetch;
    logic [AW-1:0] addr;
  } mmac_macc_t;

  typedef struct packed {
    logic valid;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mmac_sacc_t;

endpackage

// ==== verilog/mmac_unit.sv ====
// Purpose: Address translation, partition and segment checks, SFR access checks, CPU mode control
// Assumes: All inputs synchronous to ref_clk; CPU holds each access for one cycle
// Notes: Results of an access appear one cycle after it; faulting accesses never reach memory
`timescale 1ns/1ps

// Behaviour
// (RULE_01) Virtual addresses in; translated physical addresses out to memory.
// (RULE_02) Boot and Firmware Mode reach firmware EEPROM, firmware RAM, test ROM.
// (RULE_03) System and User Mode reach application parts; Test Mode all.
// (RULE_04) ROM segment rights: none, read, read-execute.
// (RULE_05) EEPROM and RAM segment rights: none, read-write, read-write-execute.
// (RULE_06) Partition split fixed at build, no run-time write.
// (RULE_07) Segments set up in System Mode, checked in User Mode.
// (RULE_08) Segment holds rights, start, end, offset and SFR rights.
// (RULE_09) Relocated address never leaves the mode's partition.
// (RULE_10) Up to 64 segments; skip and end codes shorten the table.
// (RULE_11) Out-of-bounds faults except in Test; forbidden addresses fault in User.
// (RULE_12) User and Firmware SFR rights per group, sixteen groups.
// (RULE_13) Key registers write-only, RNG read-only, gated by mode.
// (RULE_14) Disallowed or unimplemented SFR access faults.
// (RULE_15) Banked SFR: User, System and shared copies chosen by mode.
// (RULE_16) Rights outside the sixteen groups fixed in hardware.
// (RULE_17) System vector enters System, firmware vector Firmware Mode; code enters System only from User, elsewhere it faults.
// (RULE_18) Exception sets status; a second one requests device reset.
// (RULE_19) Interrupts run in the mode System software chose.
// (RULE_20) Return restores prior mode; User return needs user interrupts active.
// (RULE_21) Entry call in System Mode enters User Mode without push.
// (RULE_22) Mode register writes can only clear bits.
// (RULE_23) Faulting access is suppressed.
module mmac_unit
  import mmac_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [RAW-1:0] reg_addr,
  input wire logic [DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DW-1:0] reg_rdata,
  input wire mmac_macc_t cpu_mem,
  input wire mmac_sacc_t cpu_sfr,
  input wire mmac_evt_t cpu_evt,
  output mmac_macc_t mem_out,
  output mmac_sacc_t sfr_out,
  output logic [7:0] sfr_rdata,
  output logic [4:0] mode_out,
  output logic exc_pulse,
  output logic dev_reset_req,
  output logic push_suppress
);

  // ==========================================================================
  // Configuration state
  mmac_seg_t seg_reg [SEG_NUM];
  mmac_seg_t seg_next [SEG_NUM];
  logic [SEG_IW-1:0] seg_idx_reg, seg_idx_next;
  logic [1:0] irq_mode_reg, irq_mode_next;
  logic [SFR_GROUPS-1:0] fw_sfr_reg, fw_sfr_next;
  logic [DW-1:0] rdata_reg, rdata_next;

  // Mode and access state
  mmac_mode_t mode_reg, mode_next;
  mmac_mode_t saved_mode_reg, saved_mode_next;
  logic exc_stat_reg, exc_stat_next;
  logic irq_act_reg, irq_act_next;
  logic [SFR_GROUPS-1:0] cur_sfr_reg, cur_sfr_next;
  logic [7:0] bank_reg [3];
  logic [7:0] bank_next [3];
  mmac_macc_t mem_reg, mem_next;
  mmac_sacc_t sfr_reg, sfr_next;
  logic [7:0] srd_reg, srd_next;
  logic exc_reg, exc_next;
  logic rst_req_reg, rst_req_next;
  logic push_reg, push_next;

  logic in_sys;
  assign in_sys = (mode_reg == MODE_SYS);

  // ==========================================================================
  // Configuration port, next values
  always_comb begin
    mmac_seg_t cur;
    cur = seg_reg[seg_idx_reg];
    seg_next = seg_reg;
    seg_idx_next = seg_idx_reg;
    irq_mode_next = irq_mode_reg;
    fw_sfr_next = fw_sfr_reg;
    rdata_next = '0;
    // (RULE_07) table writes in System
    if (reg_wr && in_sys) begin
      case (reg_addr)
        OFF_SEG_INDEX: seg_idx_next = reg_wdata[SEG_IW-1:0];
        OFF_SEG_RIGHTS: begin
          seg_next[seg_idx_reg].rights = reg_wdata[2:0];
          seg_next[seg_idx_reg].sfr = reg_wdata[SEG_SFR_POS +: SFR_GROUPS];
        end
        OFF_SEG_START: seg_next[seg_idx_reg].start_a = reg_wdata[AW-1:0];
        OFF_SEG_END: seg_next[seg_idx_reg].end_a = reg_wdata[AW-1:0];
        OFF_SEG_OFFSET: seg_next[seg_idx_reg].offset = reg_wdata[AW-1:0];
        // (RULE_19) interrupt mode choice
        OFF_IRQ_MODE: irq_mode_next = reg_wdata[1:0];
        // (RULE_12) firmware SFR rights
        OFF_FW_SFR: fw_sfr_next = reg_wdata[SFR_GROUPS-1:0];
        default: begin
        end
      endcase
    end
    // Reads answer in the next cycle; unmapped offsets read zero
    if (reg_rd) begin
      case (reg_addr)
        OFF_MODE: rdata_next = {27'h0, mode_reg};
        OFF_IRQ_MODE: rdata_next = {30'h0, irq_mode_reg};
        OFF_SEG_INDEX: rdata_next = {26'h0, seg_idx_reg};
        OFF_SEG_RIGHTS: rdata_next = {cur.sfr, 13'h0, cur.rights};
        OFF_SEG_START: rdata_next = {8'h0, cur.start_a};
        OFF_SEG_END: rdata_next = {8'h0, cur.end_a};
        OFF_SEG_OFFSET: rdata_next = {8'h0, cur.offset};
        OFF_FW_SFR: rdata_next = {16'h0, fw_sfr_reg};
        OFF_STATUS: rdata_next = {30'h0, irq_act_reg, exc_stat_reg};
        default: rdata_next = '0;
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < SEG_NUM; i++) begin
        seg_reg[i] <= '0;
      end
      seg_idx_reg <= '0;
      irq_mode_reg <= IRQ_IN_SYS;
      fw_sfr_reg <= '0;
      rdata_reg <= '0;
    end else begin
      seg_reg <= seg_next;
      seg_idx_reg <= seg_idx_next;
      irq_mode_reg <= irq_mode_next;
      fw_sfr_reg <= fw_sfr_next;
      rdata_reg <= rdata_next;
    end
  end

  // ==========================================================================
  // Segment search: first live entry covering the virtual address
  logic seg_hit;
  mmac_seg_t seg_sel;
  always_comb begin
    logic stop;
    stop = 1'b0;
    seg_hit = 1'b0;
    seg_sel = '0;
    // (RULE_10) end and skip codes
    for (int i = 0; i < SEG_NUM; i++) begin
      if (!stop && !seg_hit) begin
        if (seg_reg[i].rights == RIGHT_END) begin
          stop = 1'b1;
        end else if (seg_reg[i].rights != RIGHT_SKIP && cpu_mem.addr >= seg_reg[i].start_a &&
                     cpu_mem.addr <= seg_reg[i].end_a) begin
          seg_hit = 1'b1;
          seg_sel = seg_reg[i];
        end
      end
    end
  end

  // ==========================================================================
  // Memory translation and checks
  logic [AW-1:0] paddr;
  logic in_rom_app, in_rom_test, in_ee_fw, in_ee_app, in_ram_fw, in_ram_app;
  logic oob, part_ok, seg_ok, is_rom, mem_fault;
  always_comb begin
    // (RULE_01) virtual to physical
    paddr = cpu_mem.addr;
    if (mode_reg == MODE_USER) begin
      paddr = AW'(cpu_mem.addr + seg_sel.offset);
    end
    // (RULE_06) fixed partition bounds
    in_rom_app = paddr >= ROM_APP_LO && paddr <= ROM_APP_HI;
    in_rom_test = paddr >= ROM_TEST_LO && paddr <= ROM_TEST_HI;
    in_ee_fw = paddr >= EE_FW_LO && paddr <= EE_FW_HI;
    in_ee_app = paddr >= EE_APP_LO && paddr <= EE_APP_HI;
    in_ram_fw = paddr >= RAM_FW_LO && paddr <= RAM_FW_HI;
    in_ram_app = paddr >= RAM_APP_LO && paddr <= RAM_APP_HI;
    is_rom = in_rom_app || in_rom_test;
    oob = !(is_rom || in_ee_fw || in_ee_app || in_ram_fw || in_ram_app);
    // (RULE_02) firmware partitions
    // (RULE_03) application partitions
    // (RULE_09) relocation stays inside
    case (mode_reg)
      MODE_BOOT, MODE_FW: part_ok = in_rom_test || in_ee_fw || in_ram_fw;
      MODE_SYS, MODE_USER: part_ok = in_rom_app || in_ee_app || in_ram_app;
      MODE_TEST: part_ok = 1'b1;
      default: part_ok = 1'b0;
    endcase
    // (RULE_04) ROM rights
    // (RULE_05) EEPROM and RAM rights
    seg_ok = 1'b1;
    if (mode_reg == MODE_USER) begin
      case (seg_sel.rights)
        RIGHT_R: seg_ok = !cpu_mem.wr && !cpu_mem.fetch;
        RIGHT_RX: seg_ok = !cpu_mem.wr;
        RIGHT_RW: seg_ok = !cpu_mem.fetch;
        RIGHT_RWX: seg_ok = 1'b1;
        default: seg_ok = 1'b0;
      endcase
      // (RULE_07) segments checked only here
      seg_ok = seg_ok && seg_hit;
    end
    // (RULE_11) bounds and forbidden addresses
    mem_fault = cpu_mem.valid && (((mode_reg != MODE_TEST) && oob) || !part_ok || !seg_ok ||
                                  (is_rom && cpu_mem.wr));
  end

  // ==========================================================================
  // SFR checks
  logic sfr_fault, sfr_grp, sfr_key, sfr_rng, sfr_bank;
  logic [1:0] bank_sel;
  always_comb begin
    logic [3:0] grp;
    grp = cpu_sfr.addr[6:3];
    sfr_grp = cpu_sfr.addr < SFR_GROUP_LIMIT;
    sfr_key = cpu_sfr.addr >= SFR_KEY_LO && cpu_sfr.addr <= SFR_KEY_HI;
    sfr_rng = cpu_sfr.addr == SFR_RNG;
    sfr_bank = cpu_sfr.addr == SFR_BANKED;
    // (RULE_15) copy chosen by mode
    case (mode_reg)
      MODE_USER: bank_sel = 2'h0;
      MODE_SYS: bank_sel = 2'h1;
      default: bank_sel = 2'h2;
    endcase
    sfr_fault = 1'b0;
    if (cpu_sfr.valid) begin
      if (sfr_grp) begin
        // (RULE_12) group rights by mode
        case (mode_reg)
          MODE_USER: sfr_fault = !cur_sfr_reg[grp];
          MODE_FW: sfr_fault = !fw_sfr_reg[grp];
          default: sfr_fault = 1'b0;
        endcase
      // (RULE_13) key write-only, RNG read-only
      // (RULE_16) fixed rights
      end else if (sfr_key) begin
        sfr_fault = !cpu_sfr.wr || (mode_reg == MODE_USER);
      end else if (sfr_rng) begin
        sfr_fault = cpu_sfr.wr || (mode_reg == MODE_BOOT);
      end else if (!sfr_bank) begin
        // (RULE_14) unimplemented address
        sfr_fault = 1'b1;
      end
    end
  end

  // ==========================================================================
  // Mode control and access results, next values
  logic call_entry, svc_fault, return_from_interrupt_fault, exc_any;
  always_comb begin
    // (RULE_21) entry call detection
    call_entry = (cpu_evt.long_call_instr || cpu_evt.absolute_call_instr || cpu_evt.extended_call_instr) &&
                 cpu_evt.call_addr == ENTRY_ADDR && in_sys;
    // (RULE_17) system call outside User
    svc_fault = cpu_evt.system_vector_call && mode_reg != MODE_USER;
    // (RULE_20) user return check
    return_from_interrupt_fault = cpu_evt.return_from_interrupt && mode_reg == MODE_USER &&
                 !(irq_mode_reg == IRQ_IN_USER && irq_act_reg);
    exc_any = mem_fault || sfr_fault || svc_fault || return_from_interrupt_fault;
    mode_next = mode_reg;
    saved_mode_next = saved_mode_reg;
    exc_stat_next = exc_stat_reg;
    irq_act_next = irq_act_reg;
    cur_sfr_next = cur_sfr_reg;
    bank_next = bank_reg;
    mem_next = '0;
    sfr_next = '0;
    srd_next = '0;
    exc_next = exc_any;
    rst_req_next = 1'b0;
    push_next = 1'b0;
    // (RULE_23) only clean accesses pass
    if (cpu_mem.valid && !mem_fault) begin
      mem_next = '{valid: 1'b1, wr: cpu_mem.wr, fetch: cpu_mem.fetch, addr: paddr};
      if (cpu_mem.fetch && mode_reg == MODE_USER) begin
        // (RULE_08) SFR rights of executing segment
        cur_sfr_next = seg_sel.sfr;
      end
    end
    if (cpu_sfr.valid && !sfr_fault) begin
      if (sfr_bank) begin
        if (cpu_sfr.wr) begin
          bank_next[bank_sel] = cpu_sfr.wdata;
        end else begin
          srd_next = bank_reg[bank_sel];
        end
      end else begin
        sfr_next = cpu_sfr;
      end
    end
    if (exc_any) begin
      // (RULE_18) second fault forces reset
      if (exc_stat_reg) begin
        rst_req_next = 1'b1;
      end else begin
        exc_stat_next = 1'b1;
        saved_mode_next = mode_reg;
      end
    end else if (cpu_evt.return_from_interrupt) begin
      // (RULE_20) restore prior mode
      mode_next = saved_mode_reg;
      exc_stat_next = 1'b0;
      irq_act_next = 1'b0;
    end else if (cpu_evt.system_vector_call) begin
      // (RULE_17) enter System Mode
      saved_mode_next = mode_reg;
      mode_next = MODE_SYS;
    end else if (cpu_evt.firmware_vector_call) begin
      // (RULE_17) enter Firmware Mode
      saved_mode_next = mode_reg;
      mode_next = MODE_FW;
    end else if (cpu_evt.irq_entry) begin
      // (RULE_19) interrupt runs in chosen mode
      saved_mode_next = mode_reg;
      irq_act_next = 1'b1;
      case (irq_mode_reg)
        IRQ_IN_USER: mode_next = MODE_USER;
        IRQ_IN_FW: mode_next = MODE_FW;
        default: mode_next = MODE_SYS;
      endcase
    end else if (call_entry) begin
      // (RULE_21) drop to User, no push
      mode_next = MODE_USER;
      push_next = 1'b1;
    end else if (cpu_evt.test_entry && mode_reg == MODE_BOOT) begin
      mode_next = MODE_TEST;
    end else if (reg_wr && reg_addr == OFF_MODE && (mode_reg & ~reg_wdata[4:0]) != 5'h00) begin
      // (RULE_22) clearing only lowers privilege
      case (mode_reg)
        MODE_BOOT: mode_next = MODE_FW;
        MODE_SYS: mode_next = MODE_USER;
        default: mode_next = mode_reg;
      endcase
    end
  end

  // Mode and access registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= MODE_BOOT;
      saved_mode_reg <= MODE_BOOT;
      exc_stat_reg <= 1'b0;
      irq_act_reg <= 1'b0;
      cur_sfr_reg <= '0;
      for (int i = 0; i < 3; i++) begin
        bank_reg[i] <= 8'h00;
      end
      mem_reg <= '0;
      sfr_reg <= '0;
      srd_reg <= 8'h00;
      exc_reg <= 1'b0;
      rst_req_reg <= 1'b0;
      push_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      saved_mode_reg <= saved_mode_next;
      exc_stat_reg <= exc_stat_next;
      irq_act_reg <= irq_act_next;
      cur_sfr_reg <= cur_sfr_next;
      bank_reg <= bank_next;
      mem_reg <= mem_next;
      sfr_reg <= sfr_next;
      srd_reg <= srd_next;
      exc_reg <= exc_next;
      rst_req_reg <= rst_req_next;
      push_reg <= push_next;
    end
  end

  // ==========================================================================
  // Outputs, all straight from flops
  assign reg_rdata = rdata_reg;
  assign mem_out = mem_reg;
  assign sfr_out = sfr_reg;
  assign sfr_rdata = srd_reg;
  assign mode_out = mode_reg;
  assign exc_pulse = exc_reg;
  assign dev_reset_req = rst_req_reg;
  assign push_suppress = push_reg;

endmodule
